// ==== hdl/ais_sync.sv ====
// Two-stage synchroniser for pins from the partner hardware
`timescale 1ns/100ps
`default_nettype none
module ais_sync
  import ais_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // First stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        meta_r[i] <= 1'b0;
        q_r[i]    <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q_r[i]    <= meta_r[i];
      end
    end
  end

  assign q = q_r;
endmodule : ais_sync
`default_nettype wire

// ==== hdl/ais_top.sv ====
// Architecture interrupt service unit with classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module ais_top
  import ais_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [DATA_W-1:0]     wb_dat_i,
  output logic      [DATA_W-1:0]     wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  instr_done,
  input  wire logic                  kbd_valid,
  input  wire logic                  kbd_error,
  input  wire logic [DATA_W-1:0]     kbd_data,
  output logic                       disp_valid,
  output logic      [DISP_W-1:0]     disp_char,
  input  wire logic                  disp_ack,
  input  wire logic                  disp_error,
  output logic                       sto_req,
  output logic      [STO_UNIT_W-1:0] sto_unit,
  output logic                       sto_rd,
  output logic                       sto_wr,
  output logic      [2*DATA_W-1:0]   sto_offset,
  output logic      [DATA_W-1:0]     sto_len,
  output logic      [DATA_W-1:0]     sto_mem_addr,
  input  wire logic                  sto_done,
  input  wire logic                  sto_io_err,
  input  wire logic                  sto_mem_err,
  output logic                       pg_inval,
  output logic      [DATA_W-1:0]     pg_base,
  output logic                       tmr_cfg,
  output logic      [TMR_ID_W-1:0]   tmr_sel,
  output logic      [GRAN_W-1:0]     tmr_unit,
  output logic      [DATA_W-1:0]     tmr_count,
  input  wire logic                  tmr_expire,
  input  wire logic [TMR_ID_W-1:0]   tmr_exp_id,
  output logic                       cpu_halt,
  output logic                       trap_req,
  output logic      [ID_W-1:0]       trap_id
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : byte_mask

  function automatic logic known_id(input logic [ID_W-1:0] id);
    return (id == ID_HALT) || (id == ID_DISP) || (id == ID_STO) ||
           (id == ID_PGINV) || (id == ID_TMR);
  endfunction : known_id

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_s;
  logic              kbd_valid_s, kbd_error_s, disp_ack_s, disp_error_s;
  logic              sto_done_s, sto_io_err_s, sto_mem_err_s, tmr_expire_s;
  logic [DATA_W-1:0] kbd_data_s;
  logic [TMR_ID_W-1:0] tmr_exp_id_s;

  ais_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     ({kbd_valid, kbd_error, kbd_data, disp_ack, disp_error, sto_done,
             sto_io_err, sto_mem_err, tmr_expire, tmr_exp_id}),
    .q     (pin_s)
  );
  assign {kbd_valid_s, kbd_error_s, kbd_data_s, disp_ack_s, disp_error_s, sto_done_s,
          sto_io_err_s, sto_mem_err_s, tmr_expire_s, tmr_exp_id_s} = pin_s;

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  ais_state_e        state_r;
  logic [DATA_W-1:0] gp_r [NUM_GP];
  logic [DATA_W-1:0] fault_r;
  logic [1:0]        ctrl_r;
  logic [ID_W-1:0]   cmd_id_r;
  logic              cmd_pend_r, halted_r, ack_r;
  logic              kbd_q_r, kbd_pend_r, kbd_err_r, tmr_q_r, tmr_pend_r;
  logic [DATA_W-1:0] kbd_data_r;
  logic [TMR_ID_W-1:0] tmr_id_r;

  logic bus_req, bus_wr, idle, take_hw, take_kbd, take_tmr, take_soft, soft_go;
  logic priv_ok, a64, sto_ext, gran_ok, tid_ok, resp_any;
  logic [DATA_W-1:0] soft_fault, fault_set, ff_nxt;
  logic [DATA_W-1:0] rd_mux;
  logic              fault_id_we;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign bus_wr   = bus_req & wb_we_i & ack_r;
  assign idle     = (state_r == S_IDLE) & ~halted_r;
  assign take_hw  = idle & instr_done & (kbd_pend_r | tmr_pend_r);
  assign take_kbd = take_hw & kbd_pend_r;
  assign take_tmr = take_hw & ~kbd_pend_r;
  assign take_soft = idle & cmd_pend_r & ~take_hw;
  assign priv_ok  = (ctrl_r[CTRL_PRIV] == PRIV_SUPER);
  assign a64      = ctrl_r[CTRL_A64];
  assign sto_ext  = gp_r[0][STO_EXT_BIT] & ~a64;
  assign gran_ok  = $onehot(gp_r[1][GRAN_W-1:0]);
  assign tid_ok   = gp_r[0] < DATA_W'(NUM_TIMERS);
  assign resp_any = disp_ack_s | disp_error_s | sto_done_s | sto_io_err_s | sto_mem_err_s;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Single-wait answer: ack one cycle after the request appears
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_r    <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r) begin
        wb_dat_o <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_r;

  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      OFF_GP1:   rd_mux = gp_r[0];
      OFF_GP2:   rd_mux = gp_r[1];
      OFF_GP3:   rd_mux = gp_r[2];
      OFF_GP4:   rd_mux = gp_r[3];
      OFF_GP5:   rd_mux = gp_r[4];
      OFF_CTRL:  rd_mux = {{(DATA_W-2){1'b0}}, ctrl_r};
      OFF_CMD:   rd_mux = {{(DATA_W-ID_W){1'b0}}, cmd_id_r};
      OFF_FAULT: rd_mux = fault_r;
      OFF_STAT: begin
        rd_mux[ST_HALT]  = halted_r;
        rd_mux[ST_BUSY]  = cmd_pend_r | (state_r != S_IDLE);
        rd_mux[ST_KPEND] = kbd_pend_r;
        rd_mux[ST_TPEND] = tmr_pend_r;
      end
      default:   rd_mux = '0;
    endcase
  end

  // General-purpose registers; hardware delivery beats a bus write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int g = 0; g < NUM_GP; g++) begin
        gp_r[g] <= '0;
      end
    end else begin
      for (int g = 0; g < NUM_GP; g++) begin
        if (bus_wr && wb_adr_i == ADR_W'(OFF_GP1 + 6'h04 * ADR_W'(g))) begin
          gp_r[g] <= (gp_r[g] & ~byte_mask(wb_sel_i)) | (wb_dat_i & byte_mask(wb_sel_i));
        end
      end
      if (take_kbd && !kbd_err_r) begin
        gp_r[0] <= kbd_data_r;
      end else if (take_tmr) begin
        gp_r[0] <= {{(DATA_W-TMR_ID_W){1'b0}}, tmr_id_r};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= '0;
    end else if (bus_wr && wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  // Command register; a second command is dropped while one is still pending
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_pend_r <= 1'b0;
      cmd_id_r   <= '0;
    end else if (bus_wr && wb_adr_i == OFF_CMD && wb_sel_i[0] && !cmd_pend_r && !halted_r) begin
      cmd_pend_r <= 1'b1;
      cmd_id_r   <= wb_dat_i[ID_W-1:0];
    end else if (take_soft) begin
      cmd_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hardware interrupt intake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      kbd_q_r    <= 1'b0;
      kbd_pend_r <= 1'b0;
      kbd_err_r  <= 1'b0;
      kbd_data_r <= '0;
      tmr_q_r    <= 1'b0;
      tmr_pend_r <= 1'b0;
      tmr_id_r   <= '0;
    end else begin
      kbd_q_r    <= kbd_valid_s;
      tmr_q_r    <= tmr_expire_s;
      // A new edge in the take cycle is kept pending
      kbd_pend_r <= (kbd_valid_s & ~kbd_q_r) | (kbd_pend_r & ~take_kbd);
      tmr_pend_r <= (tmr_expire_s & ~tmr_q_r) | (tmr_pend_r & ~take_tmr);
      if (kbd_valid_s && !kbd_q_r) begin
        kbd_data_r <= kbd_data_s;
        kbd_err_r  <= kbd_error_s;
      end
      if (tmr_expire_s && !tmr_q_r) begin
        tmr_id_r <= tmr_exp_id_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Service checks and fault recording
  // ----------------------------------------------------------------
  always_comb begin
    soft_fault = '0;
    if (!known_id(cmd_id_r)) begin
      soft_fault[FB_ILL_INT] = 1'b1;
    end else if (!priv_ok) begin
      soft_fault[FB_PERM] = 1'b1;
    end else if (cmd_id_r == ID_STO &&
                 gp_r[0][STO_RD_BIT] == gp_r[0][STO_WR_BIT]) begin
      soft_fault[FB_BAD_OP] = 1'b1;
    end else if (cmd_id_r == ID_TMR && !(gran_ok && tid_ok)) begin
      soft_fault[FB_BAD_OP] = 1'b1;
    end
  end
  assign soft_go = take_soft & ~|soft_fault;

  always_comb begin
    fault_set   = '0;
    fault_id_we = 1'b0;
    if (take_soft && |soft_fault) begin
      fault_set          = soft_fault;
      fault_set[FB_SOFT_INTERRUPT_INSTR] = ~soft_fault[FB_ILL_INT];
      fault_id_we        = ~soft_fault[FB_ILL_INT];
    end else if (take_kbd && kbd_err_r) begin
      fault_set[FB_IO]   = 1'b1;
      fault_set[FB_SOFT_INTERRUPT_INSTR] = 1'b1;
      fault_id_we        = 1'b1;
    end else if (state_r == S_DISP && disp_error_s) begin
      fault_set[FB_IO]   = 1'b1;
      fault_set[FB_SOFT_INTERRUPT_INSTR] = 1'b1;
      fault_id_we        = 1'b1;
    end else if (state_r == S_STO && (sto_io_err_s || sto_mem_err_s)) begin
      fault_set[FB_IO]      = sto_io_err_s;
      fault_set[FB_BAD_MEM] = sto_mem_err_s;
      fault_set[FB_SOFT_INTERRUPT_INSTR]    = 1'b1;
      fault_id_we           = 1'b1;
    end
  end

  // Write-one-to-clear; a fault arriving in the same cycle survives
  always_comb begin
    ff_nxt = fault_r;
    if (bus_wr && wb_adr_i == OFF_FAULT) begin
      ff_nxt = ff_nxt & ~(wb_dat_i & byte_mask(wb_sel_i));
    end
    ff_nxt = ff_nxt | fault_set;
    if (fault_id_we) begin
      if (take_kbd) begin
        ff_nxt[FF_ID_MSB:FF_ID_LSB] = ID_KBD;
      end else if (state_r == S_DISP) begin
        ff_nxt[FF_ID_MSB:FF_ID_LSB] = ID_DISP;
      end else if (state_r == S_STO) begin
        ff_nxt[FF_ID_MSB:FF_ID_LSB] = ID_STO;
      end else begin
        ff_nxt[FF_ID_MSB:FF_ID_LSB] = cmd_id_r;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_r <= '0;
    end else begin
      fault_r <= ff_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: four-phase handshakes with display and storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (soft_go && cmd_id_r == ID_DISP) begin
            state_r <= S_DISP;
          end else if (soft_go && cmd_id_r == ID_STO) begin
            state_r <= S_STO;
          end else if ((take_kbd && !kbd_err_r) || take_tmr) begin
            state_r <= S_TRAP;
          end
        end
        S_DISP: if (disp_ack_s || disp_error_s) state_r <= S_REL;
        S_STO:  if (sto_done_s || sto_io_err_s || sto_mem_err_s) state_r <= S_REL;
        S_REL:  if (!resp_any) state_r <= S_IDLE;
        S_TRAP: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      disp_valid <= 1'b0;
      disp_char  <= '0;
    end else if (soft_go && cmd_id_r == ID_DISP) begin
      disp_valid <= 1'b1;
      disp_char  <= gp_r[0][DISP_W-1:0];
    end else if (state_r == S_DISP && (disp_ack_s || disp_error_s)) begin
      disp_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sto_req      <= 1'b0;
      sto_unit     <= '0;
      sto_rd       <= 1'b0;
      sto_wr       <= 1'b0;
      sto_offset   <= '0;
      sto_len      <= '0;
      sto_mem_addr <= '0;
    end else if (soft_go && cmd_id_r == ID_STO) begin
      sto_req      <= 1'b1;
      sto_unit     <= gp_r[0][STO_UNIT_W-1:0];
      sto_rd       <= gp_r[0][STO_RD_BIT];
      sto_wr       <= gp_r[0][STO_WR_BIT];
      sto_offset   <= {sto_ext ? gp_r[4] : {DATA_W{1'b0}}, gp_r[1]};
      sto_len      <= gp_r[2];
      sto_mem_addr <= gp_r[3];
    end else if (state_r == S_STO && (sto_done_s || sto_io_err_s || sto_mem_err_s)) begin
      sto_req <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pg_inval  <= 1'b0;
      pg_base   <= '0;
      tmr_cfg   <= 1'b0;
      tmr_sel   <= '0;
      tmr_unit  <= '0;
      tmr_count <= '0;
      cpu_halt  <= 1'b0;
    end else begin
      pg_inval <= soft_go && cmd_id_r == ID_PGINV;
      tmr_cfg  <= soft_go && cmd_id_r == ID_TMR;
      if (soft_go && cmd_id_r == ID_PGINV) begin
        pg_base <= gp_r[0];
      end
      if (soft_go && cmd_id_r == ID_TMR) begin
        tmr_sel   <= gp_r[0][TMR_ID_W-1:0];
        tmr_unit  <= gp_r[1][GRAN_W-1:0];
        tmr_count <= gp_r[2];
      end
      if (soft_go && cmd_id_r == ID_HALT) begin
        cpu_halt <= 1'b1;
      end
    end
  end
  assign halted_r = cpu_halt;

  // Custom handler request one cycle after register one is loaded
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trap_req <= 1'b0;
      trap_id  <= '0;
    end else begin
      trap_req <= (state_r == S_TRAP);
      if (take_kbd) begin
        trap_id <= ID_KBD;
      end else if (take_tmr) begin
        trap_id <= ID_TEXP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_halt_stops: assert property (soft_go && cmd_id_r == ID_HALT |=> cpu_halt [*3])
    else $error("halt service did not stop execution");
  a_perm_record: assert property (take_soft && known_id(cmd_id_r) && !priv_ok |=>
    fault_r[FB_PERM] && fault_r[FB_SOFT_INTERRUPT_INSTR] && fault_r[FF_ID_MSB:FF_ID_LSB] == $past(cmd_id_r))
    else $error("permission fault not recorded");
  a_perm_quiet: assert property (take_soft && !priv_ok |=>
    !$rose(disp_valid) && !$rose(sto_req) && !pg_inval && !tmr_cfg && !$rose(cpu_halt))
    else $error("service acted despite a fault");
  a_kbd_deliver: assert property (take_kbd && !kbd_err_r |=> gp_r[0] == $past(kbd_data_r)
    ##1 trap_req && trap_id == ID_KBD)
    else $error("keyboard data or trap wrong");
  a_disp_byte: assert property (soft_go && cmd_id_r == ID_DISP |=>
    disp_valid && disp_char == $past(gp_r[0][DISP_W-1:0]))
    else $error("display byte not sent");
  a_disp_fail: assert property (state_r == S_DISP && disp_error_s |=>
    fault_r[FB_IO] && fault_r[FB_SOFT_INTERRUPT_INSTR] && !disp_valid)
    else $error("display failure not reported");
  a_sto_request: assert property ($rose(sto_req) |-> (sto_rd != sto_wr) &&
    sto_offset[DATA_W-1:0] == $past(gp_r[1]) && sto_len == $past(gp_r[2]))
    else $error("storage request malformed");
  a_sto_a64: assert property ($rose(sto_req) && $past(a64) |->
    sto_offset[2*DATA_W-1:DATA_W] == '0)
    else $error("extended offset used in 64-bit variant");
  a_tmr_unit: assert property (tmr_cfg |-> $onehot(tmr_unit))
    else $error("timer unit not one-hot");
  a_hw_boundary: assert property ($rose(trap_req) |-> $past(instr_done, 2))
    else $error("hardware interrupt taken mid-instruction");
  a_texp_deliver: assert property (take_tmr |-> ##2 trap_req && trap_id == ID_TEXP &&
    gp_r[0][TMR_ID_W-1:0] == $past(tmr_id_r, 2))
    else $error("timer expiry not delivered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_halt: cover property (soft_go && cmd_id_r == ID_HALT);
  c_kbd_trap: cover property (take_kbd ##2 trap_req);
  c_sto_done: cover property (state_r == S_STO ##[1:50] state_r == S_REL);
  c_tmr_cfg: cover property (tmr_cfg);
endmodule : ais_top
`default_nettype wire

// ==== inc/ais_pkg.sv ====
// Constants and types for the architecture interrupt service unit
// How it works
// - Software interrupt 0x03 halts instruction execution; it takes no parameters.
// - Every software service raises a permission fault unless privilege level is 0.
// - Any service fault other than an illegal interrupt stores the interrupt ID in byte 3 and sets bit 13.
// - Keyboard input raises trappable interrupt 0x09 with its data in register one.
// - Failed keyboard reception raises an I/O fault marked as interrupt-caused.
// - Interrupt 0x0A sends the low byte of register one to the display.
// - A failed display transfer raises an I/O fault.
// - Interrupt 0x0B takes the storage unit from low half, flags from upper half.
// - Storage flag bit 16 means read, 17 write, 18 extended offset.
// - Offset is register two; with extended flag, register five adds upper 32 bits.
// - In the 64-bit variant the extended flag and register five are ignored.
// - Register three gives transfer length, register four the memory address.
// - Storage reports permission, bad value, bad memory or I/O fault as applies.
// - Interrupt 0x0D invalidates the page-cache entry for the page in register one.
// - Interrupt 0x0F configures timer from register one, unit two, count three.
// - Granularity flags are one-hot: ns, us, ms, s in bits 0 to 3.
// - Several granularity flags or a bad timer ID raise a bad value fault.
// - Timer expiry raises trappable interrupt 0x10 with the timer ID in register one.
// - A custom handler runs only after the internal routine has finished.
// - Hardware interrupts are taken only after the current instruction completes.
`default_nettype none
package ais_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADR_W      = 6;
  localparam int unsigned ID_W       = 8;
  localparam int unsigned NUM_GP     = 5;
  localparam int unsigned SYNC_W     = 42;
  // Interrupt identifiers
  localparam logic [7:0] ID_HALT     = 8'h03;
  localparam logic [7:0] ID_KBD      = 8'h09;
  localparam logic [7:0] ID_DISP     = 8'h0a;
  localparam logic [7:0] ID_STO      = 8'h0b;
  localparam logic [7:0] ID_PGINV    = 8'h0d;
  localparam logic [7:0] ID_TMR      = 8'h0f;
  localparam logic [7:0] ID_TEXP     = 8'h10;
  // Register byte offsets
  localparam logic [5:0] OFF_GP1     = 6'h00;
  localparam logic [5:0] OFF_GP2     = 6'h04;
  localparam logic [5:0] OFF_GP3     = 6'h08;
  localparam logic [5:0] OFF_GP4     = 6'h0c;
  localparam logic [5:0] OFF_GP5     = 6'h10;
  localparam logic [5:0] OFF_CTRL    = 6'h14;
  localparam logic [5:0] OFF_CMD     = 6'h18;
  localparam logic [5:0] OFF_FAULT   = 6'h1c;
  localparam logic [5:0] OFF_STAT    = 6'h20;
  // Fault flag fields
  localparam int unsigned FB_BAD_MEM = 1;
  localparam int unsigned FB_BAD_OP  = 4;
  localparam int unsigned FB_ILL_INT = 5;
  localparam int unsigned FB_PERM    = 11;
  localparam int unsigned FB_IO      = 12;
  localparam int unsigned FB_SOFT_INTERRUPT_INSTR    = 13;
  localparam int unsigned FF_ID_LSB  = 24;
  localparam int unsigned FF_ID_MSB  = 31;
  // Storage flags and fields
  localparam int unsigned STO_RD_BIT = 16;
  localparam int unsigned STO_WR_BIT = 17;
  localparam int unsigned STO_EXT_BIT = 18;
  localparam int unsigned STO_UNIT_W = 16;
  // Timer fields
  localparam int unsigned GRAN_W     = 4;
  localparam int unsigned TMR_ID_W   = 2;
  localparam int unsigned NUM_TIMERS = 4;
  // Control and status fields
  localparam int unsigned CTRL_PRIV  = 0;
  localparam int unsigned CTRL_A64   = 1;
  localparam logic       PRIV_SUPER  = 1'b0;
  localparam int unsigned ST_HALT    = 0;
  localparam int unsigned ST_BUSY    = 1;
  localparam int unsigned ST_KPEND   = 2;
  localparam int unsigned ST_TPEND   = 3;
  localparam int unsigned DISP_W     = 8;

  typedef enum logic [2:0] {S_IDLE, S_DISP, S_STO, S_REL, S_TRAP} ais_state_e;
endpackage : ais_pkg
`default_nettype wire

// ==== test/ais_far.sv ====
// Far-side model: display and storage four-phase responders
`timescale 1ns/100ps
`default_nettype none
module ais_far (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       disp_valid,
  input  wire logic       sto_req,
  input  wire logic       fail,
  input  wire logic       mem_fail,
  input  wire logic [7:0] dly,
  output logic            disp_ack,
  output logic            disp_error,
  output logic            sto_done,
  output logic            sto_io_err,
  output logic            sto_mem_err
);
  logic [7:0] cnt;
  logic       go;
  assign go = cnt >= dly;
  // Reply after dly cycles, drop once the request drops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt <= 8'h00;
      {disp_ack, disp_error, sto_done, sto_io_err, sto_mem_err} <= '0;
    end else begin
      cnt         <= (disp_valid | sto_req) ? cnt + 8'h01 : 8'h00;
      disp_ack    <= disp_valid & ~fail & go;
      disp_error  <= disp_valid & fail & go;
      sto_done    <= sto_req & ~fail & ~mem_fail & go;
      sto_io_err  <= sto_req & fail & go;
      sto_mem_err <= sto_req & mem_fail & go;
    end
  end
endmodule : ais_far
`default_nettype wire

// ==== test/test_ais_top.sv ====
// Self-checking bench for the interrupt service unit
`timescale 1ns/100ps
`default_nettype none
module test_ais_top;
  import ais_pkg::*;
  typedef struct {logic p; logic [7:0] id; logic [31:0] g1, g2; int b;} ais_row_s;
  logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_done, kbd_valid;
  logic kbd_error, disp_valid, disp_ack, disp_error, sto_req, sto_rd, sto_wr, sto_done;
  logic sto_io_err, sto_mem_err, pg_inval, tmr_cfg, tmr_expire, cpu_halt, trap_req, fail;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i, tmr_unit;
  logic [1:0] tmr_sel, tmr_exp_id;
  logic [31:0] wb_dat_i, wb_dat_o, kbd_data, sto_len, sto_mem_addr, pg_base, tmr_count, q;
  logic [7:0] disp_char, trap_id, chr, dly;
  logic [15:0] sto_unit;
  logic [63:0] sto_offset;
  logic [145:0] sv;
  logic mem_fail;
  int miscompares, samples_checked, npg, ntm, ntr;
  ais_row_s rows[6] = '{'{1, ID_PGINV, 0, 0, FB_PERM}, '{1, ID_TMR, 9, 3, FB_PERM},
    '{0, ID_TMR, 9, 1, FB_BAD_OP}, '{0, ID_TMR, 1, 3, FB_BAD_OP}, '{0, ID_STO, 0, 0, FB_BAD_OP},
    '{0, 8'h05, 0, 0, -1}};
  ais_top u_ais_top (.*);
  ais_far u_ais_far (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    npg += pg_inval;
    ntm += tmr_cfg;
    ntr += trap_req;
    if (disp_valid) chr = disp_char;
    if (sto_req) sv = {sto_offset, sto_unit, sto_rd, sto_wr, sto_len, sto_mem_addr};
  end
  function automatic logic [31:0] fe(logic [7:0] id, int b);
    // Unknown ID: illegal-interrupt bit alone, no ID byte
    return b < 0 ? 32'h1 << FB_ILL_INT : {id, 24'h0} | (32'h1 << FB_SOFT_INTERRUPT_INSTR) | (32'h1 << b);
  endfunction : fe
  task report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [159:0] g, input logic [159:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) begin
      miscompares++;
      report_and_stop;
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge ref_clk);
  endtask : wb
  // Issue a service and poll busy, bounded
  task svc(input logic [7:0] id);
    int n;
    wb(1, OFF_CMD, {24'h0, id});
    n = 0;
    do begin
      wb(0, OFF_STAT, 0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 40);
    chk(n < 40, 1);
    if (n >= 40) report_and_stop;
  endtask : svc
  task ff(input logic [31:0] e);
    wb(0, OFF_FAULT, 0);
    chk(q, e);
    wb(1, OFF_FAULT, 32'hffffffff);
  endtask : ff
  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, kbd_valid, kbd_error, tmr_expire, fail, mem_fail} = '0;
    {wb_adr_i, wb_dat_i, kbd_data, tmr_exp_id} = '0;
    instr_done = 1'b1;
    wb_sel_i = 4'hf;
    dly = 8'h01;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    wb(0, 6'h3c, 0);
    chk({q, cpu_halt, trap_req, sto_req, disp_valid, pg_inval, tmr_cfg}, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      wb(1, OFF_CTRL, {31'h0, rows[i].p});
      wb(1, OFF_GP1, rows[i].g1);
      wb(1, OFF_GP2, rows[i].g2);
      svc(rows[i].id);
      ff(fe(rows[i].id, rows[i].b));
      $display("row %0d done", i);
    end
    chk(npg + ntm, 0);
    wb(1, OFF_CTRL, 0);
    wb(1, OFF_GP1, 32'h1000);
    svc(ID_PGINV);
    chk({npg, pg_base}, {32'h1, 32'h1000});
    wb(1, OFF_GP1, 2);
    wb(1, OFF_GP2, 4);
    wb(1, OFF_GP3, 32'h55);
    svc(ID_TMR);
    chk({ntm, tmr_sel, tmr_unit, tmr_count}, {32'h1, 2'h2, 4'h4, 32'h55});
    wb(1, OFF_GP1, 32'h12345641);
    dly <= 8'h0a;
    svc(ID_DISP);
    chk(chr, 8'h41);
    fail <= 1'b1;
    svc(ID_DISP);
    ff(fe(ID_DISP, FB_IO));
    fail <= 1'b0;
    $display("display test done");
    wb(1, OFF_GP1, 32'h00050007);
    wb(1, OFF_GP2, 32'h10);
    wb(1, OFF_GP3, 8);
    wb(1, OFF_GP4, 32'h200);
    wb(1, OFF_GP5, 3);
    svc(ID_STO);
    chk(sv, {64'h300000010, 16'h7, 2'b10, 32'h8, 32'h200});
    wb(1, OFF_CTRL, 2);
    svc(ID_STO);
    chk(sv, {64'h10, 16'h7, 2'b10, 32'h8, 32'h200});
    fail <= 1'b1;
    svc(ID_STO);
    ff(fe(ID_STO, FB_IO));
    fail <= 1'b0;
    mem_fail <= 1'b1;
    svc(ID_STO);
    ff(fe(ID_STO, FB_BAD_MEM));
    mem_fail <= 1'b0;
    $display("storage test done");
    {instr_done, kbd_data, kbd_valid} <= {1'b0, 32'habcd, 1'b1};
    repeat (10) @(posedge ref_clk);
    chk(ntr, 0);
    instr_done <= 1'b1;
    repeat (10) @(posedge ref_clk);
    wb(0, OFF_GP1, 0);
    chk({ntr, trap_id, q}, {32'h1, ID_KBD, 32'habcd});
    {kbd_valid, kbd_error} <= 2'b01;
    repeat (5) @(posedge ref_clk);
    kbd_valid <= 1'b1;
    repeat (10) @(posedge ref_clk);
    ff(fe(ID_KBD, FB_IO));
    {kbd_valid, tmr_exp_id, tmr_expire} <= {1'b0, 2'h3, 1'b1};
    repeat (10) @(posedge ref_clk);
    wb(0, OFF_GP1, 0);
    chk({ntr, trap_id, q}, {32'h2, ID_TEXP, 32'h3});
    wb(1, OFF_CTRL, 0);
    svc(ID_HALT);
    chk(cpu_halt, 1);
    wb(0, OFF_STAT, 0);
    chk(q[ST_HALT], 1);
    svc(ID_PGINV);
    chk(npg, 1);
    $display("interrupt and halt tests done");
    report_and_stop;
  end
endmodule : test_ais_top
`default_nettype wire
